// File: logic/ccpc_defines.vh
`ifndef CCPC_DEFINES_VH
`define CCPC_DEFINES_VH
// ==========================================================
// register byte addresses
`define CCPC_ADDR_CON1L    8'h00
`define CCPC_ADDR_CON1H    8'h04
`define CCPC_ADDR_CON2L    8'h08
`define CCPC_ADDR_STATUS   8'h0c
`define CCPC_ADDR_PERIOD   8'h10
`define CCPC_ADDR_COMPARE  8'h14
`define CCPC_ADDR_CAPTURE  8'h18
// ==========================================================
// writable masks (reserved bits read zero)
`define CCPC_MASK_CON1L    16'h00ff
`define CCPC_MASK_CON1H    16'hcfff
`define CCPC_MASK_CON2L    16'hd0ff
// ==========================================================
// field positions
`define CCPC_WIDE_BIT      5
`define CCPC_CAPSEL_BIT    4
`define CCPC_PSSRC_BIT     15
`define CCPC_RETRIG_BIT    14
`define CCPC_TRIGGERED_START_ENABLE_BIT    7
`define CCPC_SINGLE_TRIGGER_ENABLE_BIT   6
`define CCPC_ALTERNATE_TIMER_EVENT_OUT_BIT   5
`define CCPC_RESTART_BIT   15
`define CCPC_DEFER_BIT     14
`define CCPC_SWFORCE_BIT   12
// ==========================================================
// function codes
`define CCPC_FN_TIMER      4'h0
`define CCPC_FN_HIGH       4'h1
`define CCPC_FN_LOW        4'h2
`define CCPC_FN_TOGGLE     4'h3
`define CCPC_FN_DUAL       4'h4
`define CCPC_FN_DUALBUF    4'h5
`define CCPC_FN_CENTER     4'h6
`define CCPC_FN_EXTIN      4'hf
// ==========================================================
// sync source codes
`define CCPC_SYNC_NONE     5'h00
`define CCPC_SYNC_OWN      5'h01
`define CCPC_SYNC_FREE     5'h1f
`define CCPC_SYNC_RSV_LO   5'h1a
`define CCPC_MAX16         16'hffff
`define CCPC_RESP_OKAY     2'b00
`define CCPC_RESP_SLVERR   2'b10
`endif

// File: logic/ccpc_sync.v
`timescale 1ns/1ps
// ==========================================================
// two-flop synchroniser for a bus of pin inputs
module ccpc_sync #(
   parameter W = 1
) (
   input  wire         i_core_clk,
   input  wire         i_reset,
   input  wire [W-1:0] i_async,
   output wire [W-1:0] o_sync
);
   reg [W-1:0] meta_r;
   reg [W-1:0] sync_r;
   // first flop only feeds second
   always @(posedge i_core_clk) begin
      if (i_reset) begin
         meta_r <= {W{1'b0}};
         sync_r <= {W{1'b0}};
      end else begin
         meta_r <= i_async;
         sync_r <= meta_r;
      end
   end
   assign o_sync = sync_r;
endmodule // ccpc_sync

// File: logic/ccpc_top.v
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "ccpc_defines.vh"
module ccpc_top #(
   parameter TRIG_LEN_W = 3
) (
   input  wire        i_core_clk,
   input  wire        i_reset,
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire [7:0]  i_capture_sources,
   input  wire [31:0] i_sync_sources,
   input  wire [7:0]  i_shutdown_sources,
   input  wire [2:0]  i_trigger_length_count,
   input  wire        i_alt_sync_signal,
   output reg         o_compare_out,
   output reg         o_sync_out,
   output reg         o_interrupt,
   output reg         o_capture_overflow
);
   // ======================================================
   // registers
   reg [15:0] con1l_r;
   reg [15:0] con1h_r;
   reg [15:0] con2l_r;
   reg [31:0] period_r;
   reg [31:0] compare_r;
   reg [31:0] capture_r;
   reg [31:0] timer_r;
   reg        running_r;
   reg [TRIG_LEN_W:0] single_trigger_enable_r;
   reg [3:0]  post_r;
   reg [3:0]  edge_cnt_r;
   reg [2:0]  fifo_r;
   reg        shut_r;
   reg        pend_r;
   reg        cap_d_r;
   reg        sync_d_r;
   reg        aw_got_r;
   reg        w_got_r;
   reg [7:0]  aw_r;
   reg [31:0] w_r;
   reg [3:0]  ws_r;
   // ======================================================
   // pin synchronisers
   wire [7:0]  cap_s;
   wire [31:0] sync_s;
   wire [7:0]  sd_s;
   ccpc_sync #(.W(8)) u_cap (
      .i_core_clk (i_core_clk),
      .i_reset    (i_reset),
      .i_async    (i_capture_sources),
      .o_sync     (cap_s)
   );
   ccpc_sync #(.W(32)) u_syn (
      .i_core_clk (i_core_clk),
      .i_reset    (i_reset),
      .i_async    (i_sync_sources),
      .o_sync     (sync_s)
   );
   ccpc_sync #(.W(8)) u_sd (
      .i_core_clk (i_core_clk),
      .i_reset    (i_reset),
      .i_async    (i_shutdown_sources),
      .o_sync     (sd_s)
   );
   // ======================================================
   // field decode
   wire [3:0] fn      = con1l_r[3:0];
   wire       capsel  = con1l_r[`CCPC_CAPSEL_BIT];
   wire       wide    = con1l_r[`CCPC_WIDE_BIT];
   wire [3:0] post_n  = con1h_r[11:8];
   wire       triggered_start_enable  = con1h_r[`CCPC_TRIGGERED_START_ENABLE_BIT];
   wire       single_trigger_enable = con1h_r[`CCPC_SINGLE_TRIGGER_ENABLE_BIT];
   wire       retrig  = con1h_r[`CCPC_RETRIG_BIT];
   wire [4:0] syncsel = con1h_r[4:0];
   wire       defer   = con2l_r[`CCPC_DEFER_BIT];
   wire       swforce = con2l_r[`CCPC_SWFORCE_BIT];
   wire       restart = con2l_r[`CCPC_RESTART_BIT];
   // timer wraps at period or at ffff / full 32 bits
   function [31:0] wrap_val;
      input w;
      input [4:0] s;
      input [31:0] p;
      begin
         if (s == `CCPC_SYNC_FREE)
            wrap_val = w ? 32'hffffffff : {16'h0000, `CCPC_MAX16};
         else if (w)
            wrap_val = p;
         else
            wrap_val = {16'h0000, p[15:0]};
      end
   endfunction
   wire [31:0] wrap  = wrap_val(wide, syncsel, period_r);
   wire [31:0] cmp_t = wide ? timer_r : {16'h0000, timer_r[15:0]};
   // at or past wrap: a shorter period restarts at once
   wire        roll  = running_r && (cmp_t >= wrap);
   // narrow mode cmp_hit matches the low compare half only; the dual modes also match the high half
   wire [31:0] cmp_v = wide ? compare_r : {16'h0000, compare_r[15:0]};
   wire        cmp_hit = running_r && (cmp_t == cmp_v);
   // sync source: 00 none, own rollover, peers/pins, reserved 1a-1e
   wire        sync_in = (syncsel == `CCPC_SYNC_NONE) ? 1'b0 :
                         (syncsel == `CCPC_SYNC_OWN) ? sync_d_r :
                         (syncsel >= `CCPC_SYNC_RSV_LO) ? 1'b0 :
                         sync_s[syncsel];
   wire        trig  = sync_in && triggered_start_enable;
   // external input chosen by capture input selector
   wire [2:0]  cisel = con2l_r[2:0];
   wire        cap_in = cap_s[con1l_r[15:13]];
   wire        ext_in = cap_s[cisel];
   wire        rise  = cap_in && !cap_d_r;
   wire        fall  = !cap_in && cap_d_r;
   // shutdown request from enabled sources or software force
   wire        sd_req = (|(sd_s & con2l_r[7:0])) || swforce;
   // bus strobes used by the control logic
   wire wr_go  = aw_got_r && w_got_r && !s_axi_bvalid;
   wire sw_clear_shut = wr_go && (aw_r == `CCPC_ADDR_STATUS) &&
                        ws_r[0] && w_r[0];
   wire rd_go  = s_axi_arvalid && s_axi_arready;
   wire rd_capture = rd_go && (s_axi_araddr == `CCPC_ADDR_CAPTURE);
   // ======================================================
   // capture edge qualifier
   reg cap_evt;
   always @* begin
      cap_evt = 1'b0;
      case (fn)
         4'h0, 4'h3: cap_evt = rise | fall;
         4'h1: cap_evt = rise;
         4'h2: cap_evt = fall;
         4'h4: cap_evt = rise && (edge_cnt_r[1:0] == 2'b11);
         4'h5: cap_evt = rise && (edge_cnt_r == 4'hf);
         default: cap_evt = 1'b0;
      endcase
      cap_evt = cap_evt && capsel;
   end
   // postscaler event source
   wire ps_evt = capsel ? cap_evt :
                 (con1h_r[`CCPC_PSSRC_BIT] ? sync_d_r : roll);
   // ======================================================
   // time base, trigger, one-shot
   always @(posedge i_core_clk) begin
      if (i_reset) begin
         timer_r   <= 32'h00000000;
         running_r <= 1'b0;
         single_trigger_enable_r <= {(TRIG_LEN_W+1){1'b0}};
      end else begin
         if (!triggered_start_enable) begin
            running_r <= 1'b1;
         end else if (trig && (!running_r || retrig)) begin
            running_r <= 1'b1;
            timer_r   <= 32'h00000000;
            single_trigger_enable_r <= {1'b0, i_trigger_length_count};
         end else if (roll && single_trigger_enable) begin
            if (single_trigger_enable_r == {(TRIG_LEN_W+1){1'b0}})
               running_r <= 1'b0;
            else
               single_trigger_enable_r <= single_trigger_enable_r - 1'b1;
         end
         if (running_r && !(trig && retrig && triggered_start_enable))
            timer_r <= roll ? 32'h00000000 : timer_r + 32'h00000001;
      end
   end
   // ======================================================
   // compare output, capture, shutdown
   always @(posedge i_core_clk) begin
      if (i_reset) begin
         o_compare_out <= 1'b0;
         capture_r     <= 32'h00000000;
         edge_cnt_r    <= 4'h0;
         cap_d_r       <= 1'b0;
         shut_r        <= 1'b0;
         pend_r        <= 1'b0;
         fifo_r        <= 3'b000;
         sync_d_r      <= 1'b0;
         o_sync_out    <= 1'b0;
      end else begin
         cap_d_r  <= cap_in;
         sync_d_r <= roll;
         o_sync_out <= con1h_r[`CCPC_ALTERNATE_TIMER_EVENT_OUT_BIT] ?
                       i_alt_sync_signal : roll;
         if (capsel && rise)
            edge_cnt_r <= edge_cnt_r + 4'h1;
         if (cap_evt) begin
            capture_r <= cmp_t;
            if (fifo_r != 3'b100)
               fifo_r <= fifo_r + 3'b001;
         end
         // defer to rollover or act at once
         if (sd_req && defer && !roll)
            pend_r <= 1'b1;
         else if (roll)
            pend_r <= 1'b0;
         if ((sd_req && (!defer || roll)) || (pend_r && roll))
            shut_r <= 1'b1;
         else if (restart && !sd_req && roll)
            shut_r <= 1'b0;
         else if (sw_clear_shut)
            shut_r <= 1'b0;
         if (shut_r || capsel) begin
            o_compare_out <= 1'b0;
         end else begin
            case (fn)
               `CCPC_FN_TIMER: o_compare_out <= 1'b0;
               `CCPC_FN_HIGH:
                  if (cmp_hit)
                     o_compare_out <= 1'b1;
               `CCPC_FN_LOW:
                  if (cmp_hit)
                     o_compare_out <= 1'b0;
               `CCPC_FN_TOGGLE:
                  if (cmp_hit)
                     o_compare_out <= ~o_compare_out;
               `CCPC_FN_DUAL, `CCPC_FN_DUALBUF: begin
                  if (cmp_t[15:0] == compare_r[15:0])
                     o_compare_out <= 1'b1;
                  else if (cmp_t[15:0] == compare_r[31:16])
                     o_compare_out <= 1'b0;
               end
               `CCPC_FN_CENTER: o_compare_out <= 1'b0;
               `CCPC_FN_EXTIN: o_compare_out <= ext_in;
               default: o_compare_out <= 1'b0;
            endcase
         end
         if (rd_capture)
            fifo_r <= {2'b00, cap_evt}; // new capture wins
      end
   end
   // ======================================================
   // interrupt postscaler
   always @(posedge i_core_clk) begin
      if (i_reset) begin
         post_r             <= 4'h0;
         o_interrupt        <= 1'b0;
         o_capture_overflow <= 1'b0;
      end else begin
         o_interrupt <= 1'b0;
         if (ps_evt) begin
            if (post_r >= post_n) begin
               post_r      <= 4'h0;
               o_interrupt <= 1'b1;
            end else begin
               post_r <= post_r + 4'h1;
            end
         end
         if (capsel && cap_evt && post_n > 4'h3 && fifo_r == 3'b100)
            o_capture_overflow <= 1'b1;
         else if (rd_capture)
            o_capture_overflow <= 1'b0;
      end
   end
   // ======================================================
   // axi4-lite slave
   function [15:0] merge16;
      input [15:0] old;
      input [31:0] d;
      input [3:0]  s;
      input [15:0] m;
      begin
         merge16 = {s[1] ? d[15:8] : old[15:8],
                    s[0] ? d[7:0] : old[7:0]} & m;
      end
   endfunction
   function [31:0] merge32;
      input [31:0] old;
      input [31:0] d;
      input [3:0]  s;
      begin
         merge32 = {s[3] ? d[31:24] : old[31:24],
                    s[2] ? d[23:16] : old[23:16],
                    s[1] ? d[15:8]  : old[15:8],
                    s[0] ? d[7:0]   : old[7:0]};
      end
   endfunction
   reg        hit_w;
   reg        hit_r;
   reg [31:0] rd_nxt;
   always @* begin
      hit_w = (aw_r == `CCPC_ADDR_CON1L) || (aw_r == `CCPC_ADDR_CON1H) ||
              (aw_r == `CCPC_ADDR_CON2L) || (aw_r == `CCPC_ADDR_STATUS) ||
              (aw_r == `CCPC_ADDR_PERIOD) || (aw_r == `CCPC_ADDR_COMPARE);
      hit_r = 1'b1;
      case (s_axi_araddr)
         `CCPC_ADDR_CON1L:   rd_nxt = {16'h0000, con1l_r};
         `CCPC_ADDR_CON1H:   rd_nxt = {16'h0000, con1h_r};
         `CCPC_ADDR_CON2L:   rd_nxt = {16'h0000, con2l_r};
         `CCPC_ADDR_STATUS:  rd_nxt = {25'h0000000, fifo_r,
                                 o_capture_overflow, running_r,
                                 pend_r, shut_r};
         `CCPC_ADDR_PERIOD:  rd_nxt = period_r;
         `CCPC_ADDR_COMPARE: rd_nxt = compare_r;
         `CCPC_ADDR_CAPTURE: rd_nxt = capture_r;
         default: begin
            rd_nxt = 32'h00000000;
            hit_r  = 1'b0;
         end
      endcase
   end
   always @(posedge i_core_clk) begin
      if (i_reset) begin
         con1l_r <= 16'h0000;
         con1h_r <= 16'h0000;
         con2l_r <= 16'h0000;
         period_r  <= 32'h0000ffff;
         compare_r <= 32'h00000000;
         aw_got_r <= 1'b0;
         w_got_r  <= 1'b0;
         aw_r     <= 8'h00;
         w_r      <= 32'h00000000;
         ws_r     <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `CCPC_RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `CCPC_RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_got_r && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !w_got_r && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_r <= 1'b1;
            aw_r     <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_r <= 1'b1;
            w_r     <= s_axi_wdata;
            ws_r    <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_got_r     <= 1'b0;
            w_got_r      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= hit_w ? `CCPC_RESP_OKAY : `CCPC_RESP_SLVERR;
            case (aw_r)
               `CCPC_ADDR_CON1L:
                  con1l_r <= merge16(con1l_r, w_r, ws_r, `CCPC_MASK_CON1L);
               `CCPC_ADDR_CON1H:
                  con1h_r <= merge16(con1h_r, w_r, ws_r, `CCPC_MASK_CON1H);
               `CCPC_ADDR_CON2L:
                  con2l_r <= merge16(con2l_r, w_r, ws_r, `CCPC_MASK_CON2L);
               `CCPC_ADDR_PERIOD:
                  period_r <= merge32(period_r, w_r, ws_r);
               `CCPC_ADDR_COMPARE:
                  compare_r <= merge32(compare_r, w_r, ws_r);
               default: ;
            endcase
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_nxt;
            s_axi_rresp  <= hit_r ? `CCPC_RESP_OKAY : `CCPC_RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule // ccpc_top

// File: test/ccpc_top_asserts.sv
`timescale 1ns/1ps
`include "ccpc_defines.vh"
// ======
// bus handshake and output checks at the top ports
module ccpc_top_asserts #(
   parameter TRIG_LEN_W = 3
) (
   input wire logic        i_core_clk,
   input wire logic        i_reset,
   input wire logic [7:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        o_compare_out,
   input wire logic        o_interrupt,
   input wire logic        o_capture_overflow
);
   default clocking cb @(posedge i_core_clk);
   endclocking
   // request channel handshakes
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready;
   endsequence
   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   reset_clears_a: assert property (i_reset |=> !o_interrupt &&
      !o_compare_out && !o_capture_overflow && !s_axi_bvalid && !s_axi_rvalid)
      else $error("output set after reset");
   awready_rise_a: assert property (disable iff (i_reset)
      $rose(s_axi_awvalid) |=> s_axi_awready) else $error("awready late");
   bvalid_hold_a: assert property (disable iff (i_reset)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   write_ok_a: assert property (disable iff (i_reset)
      wr_taken ##0 (s_axi_awaddr <= 8'h14) |-> ##[1:3]
      (s_axi_bvalid && s_axi_bresp == `CCPC_RESP_OKAY)) else $error("bad bresp");
   write_err_a: assert property (disable iff (i_reset)
      wr_taken ##0 (s_axi_awaddr > 8'h18) |-> ##[1:3]
      (s_axi_bvalid && s_axi_bresp == `CCPC_RESP_SLVERR)) else $error("no err");
   rvalid_next_a: assert property (disable iff (i_reset)
      rd_taken |=> s_axi_rvalid) else $error("read data late");
   rvalid_hold_a: assert property (disable iff (i_reset)
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   read_err_a: assert property (disable iff (i_reset)
      rd_taken ##0 (s_axi_araddr > 8'h18) |=> s_axi_rvalid && s_axi_rdata == 0
      && s_axi_rresp == `CCPC_RESP_SLVERR) else $error("unmapped read");
   irq_pulse_a: assert property (disable iff (i_reset)
      o_interrupt |=> !o_interrupt) else $error("interrupt too long");
   ovf_sticky_a: assert property (disable iff (i_reset)
      o_capture_overflow && !s_axi_arvalid && !s_axi_rvalid &&
      !$past(s_axi_rvalid) |=> o_capture_overflow) else $error("ovf lost");
endmodule // ccpc_top_asserts
bind ccpc_top ccpc_top_asserts #(.TRIG_LEN_W(TRIG_LEN_W)) u_asserts (
   .i_core_clk(i_core_clk), .i_reset(i_reset),
   .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .o_compare_out(o_compare_out),
   .o_interrupt(o_interrupt), .o_capture_overflow(o_capture_overflow));

// File: test/ccpc_src_model.sv
`timescale 1ns/1ps
// ======
// far side: capture pin, peer sync lines, shutdown lines
module ccpc_src_model (
   input  wire logic        i_core_clk,
   input  wire logic [7:0]  i_shut_req,
   input  wire logic        i_alt_req,
   input  wire logic        i_cap_en,
   output wire logic [7:0]  o_cap,
   output wire logic [31:0] o_sync,
   output wire logic [7:0]  o_shut,
   output wire logic        o_alt,
   output wire logic [2:0]  o_len
);
   logic [31:0] cnt_r = 32'h0;
   logic [7:0]  shut_r = 8'h0;
   logic        alt_r = 1'b0;
   // sources move just after the edge; peers busy every cycle
   always @(posedge i_core_clk) begin
      cnt_r <= cnt_r + 32'h1;
      shut_r <= i_shut_req;
      alt_r <= i_alt_req;
   end
   assign o_cap = {7'h0, i_cap_en & cnt_r[2]}; // rising edge every 8
   assign o_sync = cnt_r ^ 32'h5a5a5a5a;
   assign o_shut = shut_r;
   assign o_alt = alt_r;
   assign o_len = 3'h2;
endmodule // ccpc_src_model

// File: test/capture_compare_pwm_control_tb_top.sv
`timescale 1ns/1ps
`include "ccpc_defines.vh"
// ======
// self-checking bench for the control block
module capture_compare_pwm_control_tb_top;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  awa = 8'h0;
   logic [7:0]  ara = 8'h0;
   logic [31:0] wd = 32'h0;
   logic [3:0]  ws = 4'hf;
   logic        awv = 1'b0;
   logic        wv = 1'b0;
   logic        bry = 1'b0;
   logic        arv = 1'b0;
   logic        rry = 1'b0;
   logic        alt = 1'b0;
   logic        cap = 1'b0;
   logic [7:0]  sreq = 8'h0;
   logic        awr, wrdy, bv, arr, rv, cmp, so, irq, ovf, alt_s;
   logic [1:0]  bre, rre;
   logic [31:0] rdat, sync_s;
   logic [7:0]  cap_s, shut_s;
   logic [2:0]  len_s;
   int          miscompares = 0;
   int          check_count = 0;
   ccpc_top dut (
      .i_core_clk(clk), .i_reset(rst), .s_axi_awaddr(awa),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
      .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
      .s_axi_bresp(bre), .s_axi_bvalid(bv), .s_axi_bready(bry),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rdat), .s_axi_rresp(rre), .s_axi_rvalid(rv),
      .s_axi_rready(rry), .i_capture_sources(cap_s),
      .i_sync_sources(sync_s), .i_shutdown_sources(shut_s),
      .i_trigger_length_count(len_s), .i_alt_sync_signal(alt_s),
      .o_compare_out(cmp), .o_sync_out(so), .o_interrupt(irq),
      .o_capture_overflow(ovf));
   ccpc_src_model u_src (
      .i_core_clk(clk), .i_shut_req(sreq), .i_alt_req(alt),
      .i_cap_en(cap), .o_cap(cap_s), .o_sync(sync_s), .o_shut(shut_s),
      .o_alt(alt_s), .o_len(len_s));
   // ======
   // clock and watchdog
   initial begin
      forever #2 clk = ~clk;
   end
   initial begin
      repeat (60000) @(posedge clk);
      miscompares++;
      results();
   end
   // ======
   // comparison, verdict and expectations
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   function automatic logic [31:0] f_mask(input logic [7:0] a,
         input logic [31:0] d);
      case (a)
         `CCPC_ADDR_CON1L: f_mask = d & 32'(`CCPC_MASK_CON1L);
         `CCPC_ADDR_CON1H: f_mask = d & 32'(`CCPC_MASK_CON1H);
         default: f_mask = d & 32'(`CCPC_MASK_CON2L);
      endcase
   endfunction
   // output changes expected over four periods for a function code
   function automatic int f_tog(input int c);
      f_tog = (c == 3) ? 4 : (c == 4 || c == 5) ? 8 : 0;
   endfunction
   // ======
   // bus tasks: requests held until taken, ready until answered
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      logic ad;
      logic dd;
      n = 0;
      ad = 1'b0;
      dd = 1'b0;
      @(posedge clk);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      while (!(ad && dd) && n < 100) begin
         @(posedge clk);
         n++;
         if (awr === 1'b1 && !ad) begin
            awv <= 1'b0;
            ad = 1'b1;
         end
         if (wrdy === 1'b1 && !dd) begin
            wv <= 1'b0;
            dd = 1'b1;
         end
      end
      while (bv !== 1'b1 && n < 200) begin
         @(posedge clk);
         n++;
      end
      if (n >= 200) miscompares++;
      check(32'(bre), (a > 8'h18) ? 32'h2 : 32'h0);
      bry <= 1'b0;
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      rry <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (arr !== 1'b1 && n < 100);
      arv <= 1'b0;
      do begin
         @(posedge clk);
         n++;
      end while (rv !== 1'b1 && n < 200);
      if (n >= 200) miscompares++;
      d = rdat;
      check(32'(rre), (a > 8'h18) ? 32'h2 : 32'h0);
      rry <= 1'b0;
   endtask
   task automatic flag(input logic [31:0] e);
      logic [31:0] d;
      axi_rd(`CCPC_ADDR_STATUS, d);
      check(d & 32'h1, e);
   endtask
   // cycles up to the next interrupt or sync pulse
   task automatic pw(input logic i, output int c);
      c = 0;
      do begin
         @(posedge clk);
         c++;
      end while ((i ? irq : so) !== 1'b1 && c < 5000);
      if (c >= 5000) miscompares++;
   endtask
   task automatic tg(input int len, output int c);
      logic p;
      c = 0;
      p = cmp;
      repeat (len) begin
         @(posedge clk);
         if (cmp !== p)
            c++;
         p = cmp;
      end
   endtask
   // ======
   // main sequence
   initial begin
      int t, g, x, k, p;
      int ns[3] = '{0, 2, 15};
      logic [31:0] d, e;
      void'($urandom(32'ha32a630b));
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      axi_rd(`CCPC_ADDR_PERIOD, d);
      check(d, 32'h0000ffff);
      for (int i = 0; i < 3; i++) begin
         axi_rd(8'(4 * i), d);
         check(d, 32'h0);
         e = $urandom;
         axi_wr(8'(4 * i), e);
         axi_rd(8'(4 * i), d);
         check(d, f_mask(8'(4 * i), e));
      end
      axi_wr(8'h40, $urandom);
      axi_rd(8'h44, d);
      check(d, 32'h0);
      p = 16 + $urandom_range(24);
      axi_wr(`CCPC_ADDR_PERIOD, 32'(p));
      axi_wr(`CCPC_ADDR_CON1H, 32'h0);
      axi_wr(`CCPC_ADDR_CON2L, 32'h0);
      axi_wr(`CCPC_ADDR_CON1L, 32'h0);
      pw(0, x);
      axi_wr(`CCPC_ADDR_STATUS, 32'h1);
      axi_wr(`CCPC_ADDR_COMPARE, {16'(3 * p / 4), 16'(p / 4)});
      pw(0, x);
      pw(0, t);
      for (int i = 0; i < 3; i++) begin
         axi_wr(`CCPC_ADDR_CON1H, (32'(ns[i]) << 8) | (32'(i == 1) << 15));
         pw(1, x);
         pw(1, g);
         check(g, (ns[i] + 1) * t);
      end
      axi_wr(`CCPC_ADDR_CON1H, 32'h20);
      alt <= 1'b1;
      repeat (6) @(posedge clk);
      check(32'(so), 32'h1);
      alt <= 1'b0;
      repeat (6) @(posedge clk);
      check(32'(so), 32'h0);
      axi_wr(`CCPC_ADDR_CON1H, 32'h0);
      for (int c = 1; c < 7; c++) begin
         axi_wr(`CCPC_ADDR_CON1L, 32'(c % 6));
         pw(0, x);
         pw(0, x);
         tg(4 * t, g);
         check(g, f_tog(c % 6));
         if (c == 1 || c == 2 || c == 6)
            check(32'(cmp), 32'(c == 1));
      end
      axi_wr(`CCPC_ADDR_CON1L, 32'h3);
      k = $urandom_range(7);
      axi_wr(`CCPC_ADDR_CON2L, 32'h1 << k);
      sreq <= 8'h1 << k;
      repeat (8) @(posedge clk);
      flag(1);
      tg(2 * t, g);
      check(g, 0);
      sreq <= 8'h0;
      repeat (2 * t) @(posedge clk);
      flag(1);
      axi_wr(`CCPC_ADDR_STATUS, 32'h1);
      flag(0);
      axi_wr(`CCPC_ADDR_CON2L, 32'h0);
      sreq <= 8'hff;
      repeat (8) @(posedge clk);
      flag(0);
      sreq <= 8'h0;
      axi_wr(`CCPC_ADDR_CON2L, 32'h1000);
      flag(1);
      axi_wr(`CCPC_ADDR_CON2L, 32'h0);
      axi_wr(`CCPC_ADDR_STATUS, 32'h1);
      flag(0);
      pw(0, x);
      axi_wr(`CCPC_ADDR_CON2L, 32'h5000);
      flag(0);
      pw(0, x);
      repeat (3) @(posedge clk);
      flag(1);
      axi_wr(`CCPC_ADDR_CON2L, 32'h8000 | (32'h1 << k));
      axi_wr(`CCPC_ADDR_STATUS, 32'h1);
      sreq <= 8'h1 << k;
      repeat (8) @(posedge clk);
      flag(1);
      sreq <= 8'h0;
      repeat (3 * t) @(posedge clk);
      flag(0);
      axi_wr(`CCPC_ADDR_CON2L, 32'h0);
      axi_wr(`CCPC_ADDR_CON1H, 32'h0400);
      axi_wr(`CCPC_ADDR_CON1L, 32'h11);
      cap <= 1'b1;
      repeat (100) @(posedge clk);
      check(32'(ovf), 32'h1);
      cap <= 1'b0;
      axi_rd(`CCPC_ADDR_CAPTURE, d);
      repeat (2) @(posedge clk);
      check(32'(ovf), 32'h0);
      results();
   end
endmodule // capture_compare_pwm_control_tb_top
